// file: logic/hbm_pkg.sv
// package for the host bus master signalling block
package hbm_pkg;
   localparam int ADDR_W = 24;
   localparam int ISA_ADDR_W = 20;
   localparam int DATA_W = 32;
   localparam int HALF_W = 16;
   localparam int PRIO_W = 4;
   localparam int CFG_PORT_BIT = 5;
   localparam int BUS_CLK_PERIOD_NS = 100;
   localparam int BUS_CLK_HIGH_PCT = 75;
   localparam int SYS_CLK_PERIOD_NS = 25;
   localparam logic [1:0] STRAP_BACKPLANE = 2'h0;
   localparam logic [PRIO_W-1:0] PRIO_RESET = 4'h0;
   localparam logic [7:0] CFG_RESET = 8'h00;

   typedef enum logic {
      HBM_READ,
      HBM_WRITE
   } hbm_dir_e;

   // one transfer request from the local side
   typedef struct packed {
      logic [DATA_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic [3:0] byteEn;
      logic write;
   } hbm_req_s;

   // one completed transfer back to the local side
   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic write;
   } hbm_rsp_s;
endpackage

// file: logic/hbm_skid_buf.sv
// two-entry valid/ready buffer
`timescale 1ns/1ps
module hbm_skid_buf #(
   parameter int WIDTH = 33,
   parameter int DEPTH = 2
) (
   input wire logic clk,
   input wire logic rstN,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wrPtr_reg;
   logic [PW-1:0] rdPtr_reg;
   logic [PW:0] count_reg;
   wire push = inValid && inReady;
   wire pop = outValid && outReady;

   assign inReady = (count_reg != (PW+1)'(DEPTH));
   assign outValid = (count_reg != '0);
   assign outData = mem[rdPtr_reg];

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wrPtr_reg] <= inData;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstN) begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (push) begin
            wrPtr_reg <= (wrPtr_reg == PW'(DEPTH-1)) ? '0 : wrPtr_reg + 1'b1;
         end
         if (pop) begin
            rdPtr_reg <= (rdPtr_reg == PW'(DEPTH-1)) ? '0 : rdPtr_reg + 1'b1;
         end
         count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule // hbm_skid_buf

// file: logic/hbm_host_bus_master.sv
// host-bus master signalling: isa lanes and backplane bus master
`timescale 1ns/1ps
module hbm_host_bus_master (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic busClk,
   input wire logic busResetDrv,
   input wire logic hostSelStrapB,
   input wire logic hostSelStrapC,
   input wire logic [7:0] cfgReg,
   input wire logic [3:0] ownPrio,
   input wire logic reqValid,
   output logic reqReady,
   input wire hbm_pkg::hbm_req_s reqIn,
   output logic rspValid,
   input wire logic rspReady,
   output hbm_pkg::hbm_rsp_s rspOut,
   output logic backplaneMode,
   output logic [hbm_pkg::ISA_ADDR_W-1:0] isaAddrOut,
   output logic isaAle,
   output logic byteHighEnN,
   output logic word_high_lane_enableN,
   output logic [hbm_pkg::DATA_W-1:0] dataOut,
   output logic [hbm_pkg::DATA_W-1:0] dataOe,
   input wire logic [hbm_pkg::DATA_W-1:0] dataIn,
   output logic [hbm_pkg::HALF_W-1:0] portIn,
   input wire logic [hbm_pkg::HALF_W-1:0] portOut,
   input wire logic ackInN,
   output logic startOutN,
   output logic startOe,
   output logic [hbm_pkg::PRIO_W-1:0] arbOutN,
   input wire logic [hbm_pkg::PRIO_W-1:0] arbInN,
   output logic ownBus
);
   localparam int RW = $bits(hbm_pkg::hbm_req_s);
   localparam int SW = $bits(hbm_pkg::hbm_rsp_s);

   // system side: reset combines sync reset with synchronised bus reset
   logic rstDrvMeta_reg;
   logic rstDrvSync_reg;
   logic [1:0] strapMeta_reg;
   logic [1:0] strapSync_reg;
   logic mode_reg;
   logic strapTaken_reg;
   logic [hbm_pkg::HALF_W-1:0] portMeta_reg;
   logic [hbm_pkg::HALF_W-1:0] port_reg;
   wire sysRstN = resetn && !rstDrvSync_reg;

   always_ff @(posedge clk_sys) begin
      rstDrvMeta_reg <= busResetDrv;
      rstDrvSync_reg <= rstDrvMeta_reg;
      strapMeta_reg <= {hostSelStrapC, hostSelStrapB};
      strapSync_reg <= strapMeta_reg;
      portMeta_reg <= dataIn[hbm_pkg::DATA_W-1:hbm_pkg::HALF_W];
      port_reg <= portMeta_reg;
   end

   // straps caught once after reset release
   always_ff @(posedge clk_sys) begin
      if (!sysRstN) begin
         mode_reg <= 1'b0;
         strapTaken_reg <= 1'b0;
      end else if (!strapTaken_reg) begin
         mode_reg <= (strapSync_reg == hbm_pkg::STRAP_BACKPLANE);
         strapTaken_reg <= 1'b1;
      end
   end

   wire portMode = cfgReg[hbm_pkg::CFG_PORT_BIT];
   always_ff @(posedge clk_sys) begin
      if (!sysRstN) begin
         backplaneMode <= 1'b0;
         portIn <= '0;
      end else begin
         backplaneMode <= mode_reg;
         portIn <= port_reg;
      end
   end

   // request buffer: a stalled bus back-pressures the requester
   logic bufValid;
   logic bufReady;
   hbm_pkg::hbm_req_s bufReq;
   hbm_skid_buf #(.WIDTH(RW), .DEPTH(2)) uReqBuf (
      .clk(clk_sys),
      .rstN(sysRstN),
      .inValid(reqValid),
      .inReady(reqReady),
      .inData(reqIn),
      .outValid(bufValid),
      .outReady(bufReady),
      .outData(bufReq)
   );

   // request handshake into bus domain (2-phase toggle)
   logic reqTgl_reg;
   logic [RW-1:0] reqHold_reg;
   logic doneMeta_reg;
   logic doneSync_reg;
   logic doneSeen_reg;
   logic busy_reg;
   hbm_pkg::hbm_rsp_s rspHold_reg;
   logic rspPend_reg;
   hbm_pkg::hbm_rsp_s busRsp_reg;
   logic doneTgl_reg;
   wire doneEvt = doneSync_reg != doneSeen_reg;
   assign bufReady = !busy_reg && !rspPend_reg;

   always_ff @(posedge clk_sys) begin
      doneMeta_reg <= doneTgl_reg;
      doneSync_reg <= doneMeta_reg;
   end

   always_ff @(posedge clk_sys) begin
      if (!sysRstN) begin
         reqTgl_reg <= 1'b0;
         reqHold_reg <= '0;
         busy_reg <= 1'b0;
         doneSeen_reg <= doneSync_reg;
         rspPend_reg <= 1'b0;
         rspHold_reg <= '0;
      end else begin
         doneSeen_reg <= doneSync_reg;
         if (bufValid && bufReady) begin
            reqHold_reg <= bufReq;
            reqTgl_reg <= !reqTgl_reg;
            busy_reg <= 1'b1;
         end else if (doneEvt) begin
            busy_reg <= 1'b0;
            rspPend_reg <= 1'b1;
            rspHold_reg <= busRsp_reg;
         end else if (rspPend_reg && (!rspValid || rspReady)) begin
            rspPend_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!sysRstN) begin
         rspValid <= 1'b0;
         rspOut <= '0;
      end else if (rspPend_reg && (!rspValid || rspReady)) begin
         rspValid <= 1'b1;
         rspOut <= rspHold_reg;
      end else if (rspReady) begin
         rspValid <= 1'b0;
      end
   end

   // isa lane selection from the held request
   hbm_pkg::hbm_req_s cur;
   assign cur = hbm_pkg::hbm_req_s'(reqHold_reg);
   wire isaByteHighN = !(cur.byteEn[1] || cur.byteEn[3]);
   wire isaWordHighN = !(cur.byteEn[2] || cur.byteEn[3]) || portMode;
   wire isaActive = busy_reg && !mode_reg;

   always_ff @(posedge clk_sys) begin
      if (!sysRstN) begin
         isaAddrOut <= '0;
         isaAle <= 1'b0;
         byteHighEnN <= 1'b1;
         word_high_lane_enableN <= 1'b1;
      end else begin
         // address valid before ale falls, which latches it
         isaAddrOut <= cur.addr[hbm_pkg::ISA_ADDR_W-1:0];
         isaAle <= isaActive && !isaAle && (bufValid && bufReady) == 1'b0
            && !doneEvt;
         byteHighEnN <= isaActive ? isaByteHighN : 1'b1;
         word_high_lane_enableN <= isaActive ? isaWordHighN : 1'b1;
      end
   end

   // ---------------- bus clock domain ----------------
   logic bRstMeta_reg;
   logic bRst_reg;
   logic reqMeta_reg;
   logic reqSync_reg;
   logic reqSeen_reg;
   logic [hbm_pkg::PRIO_W-1:0] arbSampled_reg;
   logic ackSampled_reg;
   logic [hbm_pkg::DATA_W-1:0] rdData_reg;
   typedef enum logic [2:0] {BIDLE, BARB, BSTART, BDATA, BDONE} hbm_bus_e;
   hbm_bus_e bState_reg;
   hbm_bus_e bState_next;
   wire newReq = reqSync_reg != reqSeen_reg;
   wire [hbm_pkg::PRIO_W-1:0] arbLevel = ~arbSampled_reg;
   wire won = (arbLevel == ownPrio);

   // reset reaches bus domain through two flops
   always_ff @(posedge busClk) begin
      bRstMeta_reg <= !sysRstN;
      bRst_reg <= bRstMeta_reg;
      reqMeta_reg <= reqTgl_reg;
      reqSync_reg <= reqMeta_reg;
   end

   // sampling edge: inputs taken on falling edge
   always_ff @(negedge busClk) begin
      arbSampled_reg <= arbInN;
      ackSampled_reg <= ackInN;
      if (!ackInN && bState_reg == BDATA) begin
         rdData_reg <= dataIn;
      end
   end

   always_comb begin
      bState_next = bState_reg;
      unique case (bState_reg)
         BIDLE: if (newReq && mode_reg) bState_next = BARB;
         BARB: if (won) bState_next = BSTART;
         BSTART: bState_next = BDATA;
         BDATA: if (!ackSampled_reg) bState_next = BDONE;
         BDONE: bState_next = BIDLE;
      endcase
   end

   // driving edge: all outputs change on rising edge
   always_ff @(posedge busClk) begin
      if (bRst_reg) begin
         bState_reg <= BIDLE;
         reqSeen_reg <= reqSync_reg;
         doneTgl_reg <= 1'b0;
         busRsp_reg <= '0;
      end else begin
         bState_reg <= bState_next;
         if (bState_reg == BIDLE && newReq) begin
            reqSeen_reg <= reqSync_reg;
         end
         if (bState_reg == BDONE) begin
            busRsp_reg.data <= cur.write ? cur.data : rdData_reg;
            busRsp_reg.write <= cur.write;
            doneTgl_reg <= !doneTgl_reg;
         end
      end
   end

   always_ff @(posedge busClk) begin
      if (bRst_reg) begin
         arbOutN <= '1;
         startOutN <= 1'b1;
         startOe <= 1'b0;
         ownBus <= 1'b0;
      end else begin
         // priority only while contending
         arbOutN <= (bState_next == BARB) ? ~ownPrio : '1;
         startOutN <= !(bState_next == BSTART);
         startOe <= (bState_next == BSTART);
         ownBus <= (bState_next == BSTART) || (bState_next == BDATA);
      end
   end

   // shared data lines: one driver process for both domains is avoided by
   // computing them in the bus domain for backplane, system for isa
   logic [hbm_pkg::DATA_W-1:0] adOut_reg;
   logic adOe_reg;
   always_ff @(posedge busClk) begin
      if (bRst_reg) begin
         adOut_reg <= '0;
         adOe_reg <= 1'b0;
      end else if (bState_next == BSTART) begin
         adOut_reg <= cur.addr;
         adOe_reg <= 1'b1;
      end else if (bState_next == BDATA || bState_next == BDONE) begin
         adOut_reg <= cur.data;
         adOe_reg <= cur.write;
      end else begin
         adOe_reg <= cur.write && adOe_reg && bState_reg == BDONE;
      end
   end

   // isa data path; high half becomes port output in port mode
   logic [hbm_pkg::DATA_W-1:0] isaOut_reg;
   logic [hbm_pkg::DATA_W-1:0] isaOe_reg;
   always_ff @(posedge clk_sys) begin
      if (!sysRstN) begin
         isaOut_reg <= '0;
         isaOe_reg <= '0;
      end else begin
         isaOut_reg <= portMode ? {portOut, cur.data[hbm_pkg::HALF_W-1:0]}
            : cur.data;
         isaOe_reg <= {{hbm_pkg::HALF_W{portMode
            || (isaActive && cur.write)}},
            {hbm_pkg::HALF_W{isaActive && cur.write}}};
      end
   end

   assign dataOut = mode_reg ? adOut_reg : isaOut_reg;
   assign dataOe = mode_reg ? {hbm_pkg::DATA_W{adOe_reg}} : isaOe_reg;
endmodule // hbm_host_bus_master

// file: testbench/hbm_monitor.sv
// assertions on the host bus master ports
`timescale 1ns/1ps
module hbm_monitor (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic busClk,
   input wire logic busResetDrv,
   input wire logic hostSelStrapB,
   input wire logic hostSelStrapC,
   input wire logic [7:0] cfgReg,
   input wire logic [3:0] ownPrio,
   input wire logic rspValid,
   input wire logic rspReady,
   input wire hbm_pkg::hbm_rsp_s rspOut,
   input wire logic backplaneMode,
   input wire logic word_high_lane_enableN,
   input wire logic [31:0] dataOe,
   input wire logic startOutN,
   input wire logic startOe,
   input wire logic [3:0] arbOutN,
   input wire logic ownBus
);
   logic [3:0] quiet;
   // strap is sampled a few cycles after any reset ends
   always_ff @(posedge clk_sys) begin
      if (!resetn || busResetDrv)
         quiet <= 4'h0;
      else if (quiet != 4'h8)
         quiet <= quiet + 4'h1;
   end
   sequence s_start;
      !startOutN ##1 startOutN;
   endsequence
   a_start_one: assert property (@(posedge busClk)
      disable iff (!resetn || busResetDrv) $fell(startOutN) |-> s_start)
      else $error("start strobe not one bus cycle");
   a_start_drive: assert property (@(negedge busClk)
      disable iff (!resetn || busResetDrv)
      !startOutN |-> startOe && (&dataOe)) else $error("start undriven");
   a_arb_level: assert property (@(posedge busClk)
      disable iff (!resetn || busResetDrv)
      arbOutN != 4'hF |-> arbOutN == ~ownPrio) else $error("bad priority");
   a_arb_release: assert property (@(posedge busClk)
      disable iff (!resetn || busResetDrv)
      ownBus && $past(ownBus) |-> arbOutN == 4'hF)
      else $error("priority kept after win");
   a_rsp_hold: assert property (@(posedge clk_sys)
      disable iff (!resetn || busResetDrv) rspValid && !rspReady
      |=> rspValid && $stable(rspOut)) else $error("response dropped");
   a_rsp_bound: assert property (@(posedge clk_sys)
      disable iff (!resetn || busResetDrv)
      $fell(startOutN) |-> ##[1:300] rspValid) else $error("no response");
   a_port_lanes: assert property (@(posedge clk_sys)
      disable iff (!resetn || busResetDrv) cfgReg[5] && $past(cfgReg[5], 4)
      |-> (&dataOe[31:16]) && word_high_lane_enableN)
      else $error("port lanes not driven");
   a_strap_mode: assert property (@(posedge clk_sys)
      disable iff (!resetn || busResetDrv) quiet == 4'h8
      |-> backplaneMode == !(hostSelStrapB || hostSelStrapC))
      else $error("wrong host mode");
endmodule // hbm_monitor

bind hbm_host_bus_master hbm_monitor u_mon (
   .clk_sys(clk_sys), .resetn(resetn), .busClk(busClk),
   .busResetDrv(busResetDrv), .hostSelStrapB(hostSelStrapB),
   .hostSelStrapC(hostSelStrapC), .cfgReg(cfgReg), .ownPrio(ownPrio),
   .rspValid(rspValid), .rspReady(rspReady), .rspOut(rspOut),
   .backplaneMode(backplaneMode),
   .word_high_lane_enableN(word_high_lane_enableN), .dataOe(dataOe),
   .startOutN(startOutN), .startOe(startOe), .arbOutN(arbOutN),
   .ownBus(ownBus)
);

// file: testbench/hbm_bus_model.sv
// far-side bus model: free bus clock, rival arbiter, slave
`timescale 1ns/1ps
module hbm_bus_model (
   output logic busClk,
   input wire logic startOutN,
   input wire logic [31:0] dataOut,
   input wire logic [31:0] dataOe,
   input wire logic [3:0] arbOutN,
   input wire logic [3:0] rivalN,
   input wire logic [3:0] ackDly,
   input wire logic [31:0] rdData,
   output logic ackInN,
   output logic [3:0] arbInN,
   output logic [31:0] dataIn,
   output logic [31:0] addrSeen,
   output logic [31:0] wrSeen
);
   logic [4:0] cnt;
   logic [31:0] junk;
   initial begin
      ackInN = 1'b1;
      arbInN = 4'hF;
      cnt = 5'h00;
      junk = 32'h5A5A5A5A;
      busClk = 1'b0;
      #7;
      forever begin
         busClk = 1'b1;
         #22.5;
         busClk = 1'b0;
         #7.5;
      end
   end
   // undriven lines toggle while ack is high, so a stale value cannot pass; during ack they carry rdData
   assign dataIn = (dataOe & dataOut)
      | (~dataOe & (ackInN ? junk : rdData));
   always @(negedge busClk) begin
      if (!startOutN) begin
         addrSeen <= dataIn;
         cnt <= {1'b0, ackDly} + 5'h01;
      end else if (cnt != 5'h00) begin
         cnt <= cnt - 5'h01;
      end
      if (!ackInN)
         wrSeen <= dataIn;
   end
   always @(posedge busClk) begin
      ackInN <= (cnt != 5'h01);
      arbInN <= arbOutN & rivalN;
      junk <= ~junk;
   end
endmodule // hbm_bus_model

// file: testbench/tb_top.sv
// testbench for the host bus master block
`timescale 1ns/1ps
module tb_top;
   logic clk_sys, resetn, busResetDrv, reqValid, reqReady, rspValid;
   logic rspReady, ackInN, startOutN, ownBus, busClk;
   logic [7:0] cfgReg;
   logic [15:0] portIn, portOut;
   logic [31:0] dataOut, dataOe, dataIn, rdData, addrSeen, wrSeen;
   logic [3:0] arbOutN, arbInN, rivalN, ackDly;
   logic hostSelStrapB, hostSelStrapC, backplaneMode, isaAle, byteHighEnN;
   logic word_high_lane_enableN;
   logic [19:0] isaAddrOut;
   logic [3:0] reqBe;
   hbm_pkg::hbm_req_s reqIn;
   hbm_pkg::hbm_rsp_s rspOut;
   int err_total = 0;
   int cmp_count = 0;
   hbm_host_bus_master dut (.clk_sys(clk_sys), .resetn(resetn),
      .busClk(busClk), .busResetDrv(busResetDrv),
      .hostSelStrapB(hostSelStrapB), .hostSelStrapC(hostSelStrapC),
      .cfgReg(cfgReg), .ownPrio(4'h5),
      .reqValid(reqValid), .reqReady(reqReady), .reqIn(reqIn),
      .rspValid(rspValid), .rspReady(rspReady), .rspOut(rspOut),
      .backplaneMode(backplaneMode), .isaAddrOut(isaAddrOut),
      .isaAle(isaAle), .byteHighEnN(byteHighEnN),
      .word_high_lane_enableN(word_high_lane_enableN),
      .dataOut(dataOut), .dataOe(dataOe),
      .dataIn(dataIn), .portIn(portIn), .portOut(portOut),
      .ackInN(ackInN), .startOutN(startOutN), .startOe(),
      .arbOutN(arbOutN), .arbInN(arbInN), .ownBus(ownBus));
   hbm_bus_model u_bus (.busClk(busClk), .startOutN(startOutN),
      .dataOut(dataOut), .dataOe(dataOe), .arbOutN(arbOutN),
      .rivalN(rivalN), .ackDly(ackDly), .rdData(rdData),
      .ackInN(ackInN), .arbInN(arbInN), .dataIn(dataIn),
      .addrSeen(addrSeen), .wrSeen(wrSeen));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
         input string what);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic send(input logic [31:0] a, d, input logic w, last);
      int i;
      reqIn <= '{addr: a, data: d, byteEn: reqBe, write: w};
      reqValid <= 1'b1;
      i = 0;
      // request stands until an edge at which ready is sampled high
      do begin
         @(posedge clk_sys);
         i++;
      end while (reqReady !== 1'b1 && i < 400);
      if (last)
         reqValid <= 1'b0;
      if (reqReady !== 1'b1) begin
         err_total++;
         finish_test();
      end
   endtask
   task automatic take(input logic [31:0] d, input logic w);
      int i;
      i = 0;
      // response is taken at the edge of the handshake itself
      do begin
         @(posedge clk_sys);
         i++;
      end while (rspValid !== 1'b1 && i < 400);
      if (rspValid !== 1'b1) begin
         err_total++;
         finish_test();
      end
      if (!w)
         chk(rspOut.data, d, "read data");
      chk(32'(rspOut.write), 32'(w), "rsp kind");
   endtask
   task automatic xfer(input logic [31:0] a, d, input logic w);
      rdData <= d;
      send(a, d, w, 1'b1);
      take(d, w);
      chk(addrSeen, a, "start address");
      if (w)
         chk(wrSeen, d, "write data at ack");
   endtask
   task automatic t_basic;
      xfer(32'h00123400, 32'hCAFEF00D, 1'b1);
      ackDly <= 4'h6;
      xfer(32'h00FFFFFC, 32'h89ABCDEF, 1'b0);
      ackDly <= 4'h0;
      $display("test basic done");
   endtask
   task automatic t_stall;
      rspReady <= 1'b0;
      send(32'h00000010, 32'h11112222, 1'b1, 1'b0);
      send(32'h00000014, 32'h33334444, 1'b1, 1'b1);
      tick(80);
      chk(32'(rspValid), 32'h1, "stalled response");
      rspReady <= 1'b1;
      take(32'h0, 1'b1);
      take(32'h0, 1'b1);
      chk(wrSeen, 32'h33334444, "second write data");
      $display("test stall done");
   endtask
   task automatic t_arb;
      // a rival of higher level holds the bus away from us
      rivalN <= 4'h0;
      send(32'h00000020, 32'h0BADBEEF, 1'b1, 1'b1);
      tick(30);
      chk(32'(startOutN), 32'h1, "start while losing");
      chk(32'(arbOutN), 32'hA, "priority lines");
      rivalN <= 4'hF;
      take(32'h0, 1'b1);
      $display("test arb done");
   endtask
   // straps are only taken after a reset, so a mode change resets
   task automatic straps(input logic isa);
      hostSelStrapB <= isa;
      hostSelStrapC <= isa;
      busResetDrv <= 1'b1;
      tick(12);
      busResetDrv <= 1'b0;
      tick(40);
   endtask
   task automatic isa_req(input logic [3:0] be, input logic [31:0] a);
      int i;
      reqBe = be;
      send(a, 32'h12345678, 1'b1, 1'b1);
      for (i = 0; i < 20 && isaAle !== 1'b1; i++)
         @(posedge clk_sys);
      if (isaAle !== 1'b1) begin
         err_total++;
         finish_test();
      end
      chk(32'(isaAddrOut), a & 32'h000FFFFF, "isa address");
      chk(dataOut, 32'h12345678, "isa data");
      chk(dataOe, 32'hFFFFFFFF, "isa lanes driven");
      chk(32'(backplaneMode), 32'h0, "isa mode");
   endtask
   task automatic t_port;
      straps(1'b1);
      isa_req(4'h2, 32'h00ABCDE4);
      chk(32'(byteHighEnN), 32'h0, "byte high enable");
      chk(32'(word_high_lane_enableN), 32'h1, "word high enable");
      straps(1'b1);
      isa_req(4'h4, 32'h00012342);
      chk(32'(byteHighEnN), 32'h1, "byte high enable");
      chk(32'(word_high_lane_enableN), 32'h0, "word high enable");
      cfgReg <= 8'h20;
      portOut <= 16'hA5C3;
      tick(12);
      chk(32'(dataOut[31:16]), 32'hA5C3, "port out");
      chk(32'(portIn), 32'hA5C3, "port in");
      chk(32'(word_high_lane_enableN), 32'h1, "port word enable");
      cfgReg <= 8'h00;
      reqBe = 4'hF;
      straps(1'b0);
      chk(32'(backplaneMode), 32'h1, "backplane mode");
      $display("test port done");
   endtask
   task automatic t_abort;
      ackDly <= 4'hF;
      send(32'h00000030, 32'h0, 1'b0, 1'b1);
      tick(6);
      busResetDrv <= 1'b1;
      tick(12);
      chk(dataOe, 32'h0, "lines released");
      chk(32'(rspValid), 32'h0, "aborted response");
      chk(32'(arbOutN), 32'hF, "arb idle");
      busResetDrv <= 1'b0;
      ackDly <= 4'h0;
      tick(40);
      xfer(32'h00000040, 32'h55AA55AA, 1'b1);
      $display("test abort done");
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   initial begin
      resetn = 1'b0;
      busResetDrv = 1'b0;
      hostSelStrapB = 1'b0;
      hostSelStrapC = 1'b0;
      reqBe = 4'hF;
      cfgReg = 8'h00;
      reqValid = 1'b0;
      reqIn = '0;
      rspReady = 1'b1;
      portOut = 16'h0000;
      rivalN = 4'hF;
      ackDly = 4'h0;
      rdData = 32'h0;
      tick(16);
      resetn <= 1'b1;
      tick(20);
      t_basic();
      t_stall();
      t_arb();
      t_port();
      t_abort();
      finish_test();
   end
endmodule // tb_top
